// ===== design/lcsp_cdb_check.sv
// Command block field extraction and legality check
`timescale 1ns/1ps
module lcsp_cdb_check (
  input wire logic [79:0] cdb, // Command block, byte 0 in bits 79:72
  output logic reset_all_counters_bit, // Reset-all request
  output lcsp_pkg::lcsp_pc_t page_control_field, // Page control
  output logic [15:0] list_len, // Parameter list length in bytes
  output logic illegal // Field combination refused
);
  function automatic logic [7:0] cdb_byte(input logic [79:0] c, input int i);
    return c[79 - 8 * i -: 8];
  endfunction : cdb_byte

  // Save request, vendor bits and reserved fields are not looked at
  logic [7:0] flags_byte;
  logic [7:0] pc_byte;
  assign flags_byte = cdb_byte(cdb, lcsp_pkg::LCSP_CDB_FLAGS_BYTE);
  assign pc_byte = cdb_byte(cdb, lcsp_pkg::LCSP_PC_BYTE);
  assign reset_all_counters_bit = flags_byte[lcsp_pkg::LCSP_RESET_ALL_POS];
  assign page_control_field = lcsp_pkg::lcsp_pc_t'(pc_byte[lcsp_pkg::LCSP_PC_MSB -: 2]);
  assign list_len = {cdb_byte(cdb, lcsp_pkg::LCSP_LEN_MSB_BYTE),
                     cdb_byte(cdb, lcsp_pkg::LCSP_LEN_LSB_BYTE)};

  always_comb begin
    illegal = 1'b0;
    if (list_len > lcsp_pkg::LCSP_MAX_LIST_LEN) begin
      illegal = 1'b1;
    end
    if (reset_all_counters_bit && list_len != 16'h0000) begin
      illegal = 1'b1;
    end
    if (!reset_all_counters_bit && page_control_field[1] && list_len != 16'h0000) begin
      illegal = 1'b1;
    end
  end
endmodule : lcsp_cdb_check

// ===== design/lcsp_parser.sv
// Log counter select command parser and counter store
//
// Overview of operation
// - Reset-all clears values, enables; thresholds all ones
// - Reset-all with list length gives illegal request
// - Page control 00b thresholds, 01b cumulative values
// - 10b defaults thresholds; 11b clears cumulative values
// - 10b/11b with list length gives illegal request
// - List length from bytes 7-8; zero means no data
// - Accept list lengths zero to 255 only
// - Page code 02h write, 03h read page
// - Several headers per command, one page each
// - Header bytes 2-3 give page length, MSB first
// - Parameter: code, control byte, length, big-endian value
// - Zero or more parameters, any code order
// - Command byte 9 vendor bits have no function
// - Codes 0002h-0006h select the five counters
// - Met criteria: always, equal, differ, above threshold
`timescale 1ns/1ps
module lcsp_parser (
  input wire logic clk, // 200 MHz clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic cmd_valid, // Command block offered
  input wire logic [79:0] cmd_cdb, // Command block, byte 0 in bits 79:72
  output logic cmd_busy, // Command in progress
  input wire logic dout_valid, // Data Out byte offered
  input wire logic [7:0] dout_data, // Data Out byte
  output logic dout_ready, // Data Out byte taken when valid
  output logic cmd_done, // Command finished, one cycle
  output logic cmd_check, // Check condition for last command
  output logic [3:0] sense_key, // Sense key of last command
  output logic [7:0] sense_asc, // Additional sense code
  output logic [7:0] sense_ascq, // Additional sense qualifier
  output logic [7:0] sense_fsc, // Fault symptom code
  input wire logic upd_valid, // Counter update from the drive
  input wire logic upd_page, // Update page, 1 for read page
  input wire logic [2:0] upd_idx, // Counter index 0..4
  input wire logic [39:0] upd_value, // New cumulative value
  output logic thr_met, // Threshold criteria met, one cycle
  output logic thr_met_page, // Page of the met counter
  output logic [2:0] thr_met_idx, // Index of the met counter
  input wire logic rd_page, // Readback page
  input wire logic [2:0] rd_idx, // Readback counter index
  output logic [39:0] rd_cum, // Cumulative value readback
  output logic [39:0] rd_thr, // Threshold readback
  output logic rd_etc, // Comparison enable readback
  output logic rd_du, // Update disable readback
  output logic [1:0] rd_tmc // Met criteria readback
);
  localparam int NE = lcsp_pkg::LCSP_ENTRIES;
  localparam int VW = lcsp_pkg::LCSP_VALUE_BITS;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] ent(input logic pg, input logic [2:0] ix);
    return pg ? 4'(ix) + 4'h5 : {1'b0, ix};
  endfunction : ent

  function automatic logic [VW-1:0] mask_of(input logic [3:0] e);
    logic [2:0] ix;
    ix = (e >= 4'h5) ? 3'(e - 4'h5) : e[2:0];
    return (VW'(1) << (8 * lcsp_pkg::LCSP_CNT_BYTES[ix])) - VW'(1);
  endfunction : mask_of

  function automatic logic met(input logic [1:0] threshold_met_criteria, input logic [VW-1:0] v,
                               input logic [VW-1:0] t);
    unique case (lcsp_pkg::lcsp_tmc_t'(threshold_met_criteria))
      lcsp_pkg::LCSP_TMC_ALWAYS: return 1'b1;
      lcsp_pkg::LCSP_TMC_EQUAL: return v == t;
      lcsp_pkg::LCSP_TMC_DIFFER: return v != t;
      lcsp_pkg::LCSP_TMC_ABOVE: return v > t;
    endcase
  endfunction : met

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic reset_all_counters_bit;
  lcsp_pkg::lcsp_pc_t page_control_field;
  logic [15:0] list_len;
  logic illegal;
  lcsp_pkg::lcsp_state_t state_q;
  logic accept;

  lcsp_cdb_check u_cdb (
    .cdb(cmd_cdb),
    .reset_all_counters_bit(reset_all_counters_bit),
    .page_control_field(page_control_field),
    .list_len(list_len),
    .illegal(illegal)
  );

  assign accept = cmd_valid && state_q == lcsp_pkg::LCSP_ST_IDLE;
  assign cmd_busy = state_q != lcsp_pkg::LCSP_ST_IDLE;
  assign cmd_done = state_q == lcsp_pkg::LCSP_ST_DONE;
  assign dout_ready = state_q inside {lcsp_pkg::LCSP_ST_HDR, lcsp_pkg::LCSP_ST_PAR,
                                      lcsp_pkg::LCSP_ST_VAL};

  // ----------------------------------------------------------------
  // Parser state
  // ----------------------------------------------------------------
  logic take;
  logic [7:0] list_rem_q;
  logic [15:0] page_rem_q;
  logic [15:0] page_rem_dec;
  logic [7:0] val_rem_q;
  logic [1:0] idx_q;
  logic page_sel_q;
  logic page_ok_q;
  logic [15:0] code_q;
  logic [7:0] ctrl_q;
  lcsp_pkg::lcsp_pc_t pc_q;
  logic param_end;
  logic apply;
  logic [VW-1:0] acc_q;
  logic [VW-1:0] acc_next;

  assign take = dout_valid && dout_ready;
  assign page_rem_dec = page_rem_q - 16'h0001;
  assign param_end = take && ((state_q == lcsp_pkg::LCSP_ST_PAR && idx_q == 2'h3
                               && dout_data == 8'h00)
                              || (state_q == lcsp_pkg::LCSP_ST_VAL && val_rem_q == 8'h01));
  assign apply = param_end && page_ok_q && code_q >= lcsp_pkg::LCSP_CODE_FIRST
                 && code_q <= lcsp_pkg::LCSP_CODE_LAST;

  lcsp_value_acc #(.WIDTH(VW)) u_acc (
    .clk(clk),
    .rst(rst),
    .clear(take && state_q == lcsp_pkg::LCSP_ST_PAR),
    .shift(take && state_q == lcsp_pkg::LCSP_ST_VAL),
    .data_byte(dout_data),
    .value_q(acc_q),
    .value_next(acc_next)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= lcsp_pkg::LCSP_ST_IDLE;
      list_rem_q <= 8'h00;
      page_rem_q <= 16'h0000;
      val_rem_q <= 8'h00;
      idx_q <= 2'h0;
    end else begin
      unique case (state_q)
        lcsp_pkg::LCSP_ST_IDLE: begin
          if (accept) begin
            list_rem_q <= list_len[7:0];
            idx_q <= 2'h0;
            state_q <= (illegal || list_len == 16'h0000) ? lcsp_pkg::LCSP_ST_DONE
                       : lcsp_pkg::LCSP_ST_HDR;
          end
        end
        lcsp_pkg::LCSP_ST_HDR: begin
          if (take) begin
            idx_q <= idx_q + 2'h1;
            if (idx_q == 2'h2) begin
              page_rem_q[15:8] <= dout_data;
            end
            if (idx_q == 2'h3) begin
              page_rem_q[7:0] <= dout_data;
              state_q <= ({page_rem_q[15:8], dout_data} == 16'h0000)
                         ? lcsp_pkg::LCSP_ST_HDR : lcsp_pkg::LCSP_ST_PAR;
            end
          end
        end
        lcsp_pkg::LCSP_ST_PAR: begin
          if (take) begin
            idx_q <= idx_q + 2'h1;
            page_rem_q <= page_rem_dec;
            if (idx_q == 2'h3) begin
              val_rem_q <= dout_data;
              if (dout_data != 8'h00) begin
                state_q <= lcsp_pkg::LCSP_ST_VAL;
              end else if (page_rem_dec == 16'h0000) begin
                state_q <= lcsp_pkg::LCSP_ST_HDR;
              end
            end
          end
        end
        lcsp_pkg::LCSP_ST_VAL: begin
          if (take) begin
            val_rem_q <= val_rem_q - 8'h01;
            page_rem_q <= page_rem_dec;
            if (val_rem_q == 8'h01) begin
              idx_q <= 2'h0;
              state_q <= (page_rem_dec == 16'h0000) ? lcsp_pkg::LCSP_ST_HDR
                         : lcsp_pkg::LCSP_ST_PAR;
            end
          end
        end
        lcsp_pkg::LCSP_ST_DONE: begin
          state_q <= lcsp_pkg::LCSP_ST_IDLE;
        end
        default: begin
          state_q <= lcsp_pkg::LCSP_ST_IDLE;
        end
      endcase
      if (take) begin
        list_rem_q <= list_rem_q - 8'h01;
        if (list_rem_q == 8'h01) begin
          state_q <= lcsp_pkg::LCSP_ST_DONE;
        end
      end
    end
  end

  // Header and parameter fields
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      page_sel_q <= 1'b0;
      page_ok_q <= 1'b0;
      code_q <= 16'h0000;
      ctrl_q <= 8'h00;
      pc_q <= lcsp_pkg::LCSP_PC_THRESHOLD;
    end else begin
      if (accept) begin
        pc_q <= page_control_field;
      end
      if (take && state_q == lcsp_pkg::LCSP_ST_HDR && idx_q == 2'h0) begin
        page_ok_q <= dout_data[5:0] == lcsp_pkg::LCSP_PAGE_WRITE
                     || dout_data[5:0] == lcsp_pkg::LCSP_PAGE_READ;
        page_sel_q <= dout_data[5:0] == lcsp_pkg::LCSP_PAGE_READ;
      end
      if (take && state_q == lcsp_pkg::LCSP_ST_PAR) begin
        if (idx_q == 2'h0) begin
          code_q[15:8] <= dout_data;
        end
        if (idx_q == 2'h1) begin
          code_q[7:0] <= dout_data;
        end
        if (idx_q == 2'h2) begin
          ctrl_q <= dout_data;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter store
  // ----------------------------------------------------------------
  logic [VW-1:0] cum_q [NE];
  logic [VW-1:0] thr_q [NE];
  logic [NE-1:0] etc_q;
  logic [NE-1:0] du_q;
  logic [1:0] tmc_q [NE];
  logic [3:0] apply_ent;
  logic [VW-1:0] apply_val;
  logic [3:0] upd_ent;
  logic upd_ok;
  logic bulk_thr;
  logic bulk_cum;

  assign apply_ent = ent(page_sel_q, 3'(code_q - lcsp_pkg::LCSP_CODE_FIRST));
  assign apply_val = (state_q == lcsp_pkg::LCSP_ST_VAL) ? acc_next : '0;
  assign upd_ent = ent(upd_page, upd_idx);
  assign upd_ok = upd_valid && upd_idx < 3'(lcsp_pkg::LCSP_COUNTERS);
  assign bulk_thr = accept && !illegal && (reset_all_counters_bit
                    || page_control_field == lcsp_pkg::LCSP_PC_DEFAULT_THR);
  assign bulk_cum = accept && !illegal && (reset_all_counters_bit
                    || page_control_field == lcsp_pkg::LCSP_PC_CLEAR_CUM);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NE; i++) begin
        cum_q[i] <= '0;
        thr_q[i] <= mask_of(4'(i));
        tmc_q[i] <= 2'h0;
      end
      etc_q <= '0;
      du_q <= '0;
    end else begin
      if (upd_ok && !du_q[upd_ent]) begin
        cum_q[upd_ent] <= upd_value & mask_of(upd_ent);
      end
      for (int i = 0; i < NE; i++) begin
        if (bulk_thr) begin
          thr_q[i] <= mask_of(4'(i));
          etc_q[i] <= 1'b0;
        end
        if (bulk_cum) begin
          cum_q[i] <= '0;
        end
      end
      if (apply) begin
        if (pc_q == lcsp_pkg::LCSP_PC_THRESHOLD) begin
          thr_q[apply_ent] <= apply_val & mask_of(apply_ent);
        end else begin
          cum_q[apply_ent] <= apply_val & mask_of(apply_ent);
        end
        du_q[apply_ent] <= ctrl_q[lcsp_pkg::LCSP_UPD_DIS_POS];
        etc_q[apply_ent] <= ctrl_q[lcsp_pkg::LCSP_CMP_EN_POS];
        tmc_q[apply_ent] <= ctrl_q[lcsp_pkg::LCSP_TMC_LSB +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, threshold events and readback
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_check <= 1'b0;
      sense_key <= 4'h0;
      sense_asc <= 8'h00;
      sense_ascq <= 8'h00;
      sense_fsc <= 8'h00;
    end else if (accept) begin
      cmd_check <= illegal;
      sense_key <= illegal ? lcsp_pkg::LCSP_KEY_ILLEGAL : 4'h0;
      sense_asc <= illegal ? lcsp_pkg::LCSP_ASC_INVALID_FIELD : 8'h00;
      sense_ascq <= lcsp_pkg::LCSP_ASCQ_INVALID_FIELD;
      sense_fsc <= illegal ? lcsp_pkg::LCSP_FSC_INVALID_FIELD : 8'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thr_met <= 1'b0;
      thr_met_page <= 1'b0;
      thr_met_idx <= 3'h0;
    end else begin
      thr_met <= upd_ok && !du_q[upd_ent] && etc_q[upd_ent]
                 && met(tmc_q[upd_ent], upd_value & mask_of(upd_ent), thr_q[upd_ent]);
      thr_met_page <= upd_page;
      thr_met_idx <= upd_idx;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_cum <= '0;
      rd_thr <= '0;
      rd_etc <= 1'b0;
      rd_du <= 1'b0;
      rd_tmc <= 2'h0;
    end else if (rd_idx < 3'(lcsp_pkg::LCSP_COUNTERS)) begin
      rd_cum <= cum_q[ent(rd_page, rd_idx)];
      rd_thr <= thr_q[ent(rd_page, rd_idx)];
      rd_etc <= etc_q[ent(rd_page, rd_idx)];
      rd_du <= du_q[ent(rd_page, rd_idx)];
      rd_tmc <= tmc_q[ent(rd_page, rd_idx)];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_illegal_sense: assert property (accept && illegal |=> cmd_check && cmd_done
    && sense_key == 4'h5 && sense_asc == 8'h24 && sense_fsc == 8'hCE)
    else $error("illegal command not reported");
  a_pc_high_len: assert property (accept && !reset_all_counters_bit
    && page_control_field[1] && list_len != 16'h0000 |=> cmd_check)
    else $error("page control 1x with data not refused");
  a_len_limit: assert property (accept && list_len > 16'h00FF |=> cmd_check)
    else $error("list length above 255 accepted");
  a_zero_len: assert property (accept && list_len == 16'h0000 |=> cmd_done ##1 !cmd_busy)
    else $error("zero length command not finished at once");
  a_idle_no_take: assert property (!cmd_busy |-> !dout_ready)
    else $error("data taken outside a command");
  a_reset_all: assert property (accept && !illegal && reset_all_counters_bit |=>
    cum_q[0] == '0 && thr_q[0] == 40'h0000FFFFFF && thr_q[9] == 40'h000000FFFF
    && etc_q == '0)
    else $error("reset-all left counters set");
  a_clear_cum: assert property (accept && !illegal && !reset_all_counters_bit
    && page_control_field == lcsp_pkg::LCSP_PC_CLEAR_CUM && !upd_valid
    |=> cum_q[8] == '0 && thr_q[8] == $past(thr_q[8]))
    else $error("cumulative clear wrong");
  a_hdr_len: assert property (take && state_q == lcsp_pkg::LCSP_ST_HDR && idx_q == 2'h3
    |=> page_rem_q == {$past(page_rem_q[15:8]), $past(dout_data)})
    else $error("page length not captured");
  a_list_end: assert property (take && list_rem_q == 8'h01 |=> cmd_done ##1 !cmd_busy)
    else $error("command not ended with list");
  a_du_hold: assert property (upd_ok && du_q[upd_ent] && !apply && !bulk_cum
    && upd_ent == 4'h4 |=> cum_q[4] == $past(cum_q[4]) && !thr_met)
    else $error("update disable ignored");

  c_reset_all: cover property (accept && reset_all_counters_bit && !illegal);
  c_threshold_load: cover property (apply && pc_q == lcsp_pkg::LCSP_PC_THRESHOLD);
  c_two_headers: cover property (take && state_q == lcsp_pkg::LCSP_ST_HDR
    && idx_q == 2'h0 && page_rem_q == 16'h0000 ##[1:255] cmd_done);
  c_thr_met: cover property (thr_met);
endmodule : lcsp_parser

// ===== design/lcsp_pkg.sv
// Constants and types shared by the log counter select parser
package lcsp_pkg;
  // ----------------------------------------------------------------
  // Command block layout
  // ----------------------------------------------------------------
  localparam int LCSP_CDB_BYTES = 10;
  localparam int LCSP_CDB_FLAGS_BYTE = 1;
  localparam int LCSP_RESET_ALL_POS = 1;
  localparam int LCSP_PC_BYTE = 2;
  localparam int LCSP_PC_MSB = 7;
  localparam int LCSP_LEN_MSB_BYTE = 7;
  localparam int LCSP_LEN_LSB_BYTE = 8;
  localparam logic [15:0] LCSP_MAX_LIST_LEN = 16'h00FF;
  // ----------------------------------------------------------------
  // List header and log parameter layout
  // ----------------------------------------------------------------
  localparam logic [5:0] LCSP_PAGE_WRITE = 6'h02;
  localparam logic [5:0] LCSP_PAGE_READ = 6'h03;
  localparam logic [15:0] LCSP_CODE_FIRST = 16'h0002;
  localparam logic [15:0] LCSP_CODE_LAST = 16'h0006;
  localparam int LCSP_UPD_DIS_POS = 7;
  localparam int LCSP_CMP_EN_POS = 4;
  localparam int LCSP_TMC_LSB = 2;
  localparam int LCSP_VALUE_BITS = 40;
  localparam int LCSP_COUNTERS = 5;
  localparam int LCSP_ENTRIES = 10;
  // Byte width of counters 0002h..0006h
  localparam int LCSP_CNT_BYTES [LCSP_COUNTERS] = '{3, 3, 3, 5, 2};
  // ----------------------------------------------------------------
  // Sense answer for an illegal field combination
  // ----------------------------------------------------------------
  localparam logic [3:0] LCSP_KEY_ILLEGAL = 4'h5;
  localparam logic [7:0] LCSP_ASC_INVALID_FIELD = 8'h24;
  localparam logic [7:0] LCSP_ASCQ_INVALID_FIELD = 8'h00;
  localparam logic [7:0] LCSP_FSC_INVALID_FIELD = 8'hCE;
  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LCSP_PC_THRESHOLD = 2'h0,
    LCSP_PC_CUMULATIVE = 2'h1,
    LCSP_PC_DEFAULT_THR = 2'h2,
    LCSP_PC_CLEAR_CUM = 2'h3
  } lcsp_pc_t;
  typedef enum logic [1:0] {
    LCSP_TMC_ALWAYS = 2'h0,
    LCSP_TMC_EQUAL = 2'h1,
    LCSP_TMC_DIFFER = 2'h2,
    LCSP_TMC_ABOVE = 2'h3
  } lcsp_tmc_t;
  typedef enum logic [2:0] {
    LCSP_ST_IDLE = 3'h0,
    LCSP_ST_HDR = 3'h1,
    LCSP_ST_PAR = 3'h3,
    LCSP_ST_VAL = 3'h2,
    LCSP_ST_DONE = 3'h6
  } lcsp_state_t;
endpackage : lcsp_pkg

// ===== design/lcsp_value_acc.sv
// Big-endian accumulator for a log parameter value
`timescale 1ns/1ps
module lcsp_value_acc #(
  parameter int WIDTH = 40 // Bits kept of the value
) (
  input wire logic clk, // Clock
  input wire logic rst, // Asynchronous reset
  input wire logic clear, // Start a new value
  input wire logic shift, // Take one byte
  input wire logic [7:0] data_byte, // Byte taken, most significant first
  output logic [WIDTH-1:0] value_q, // Value so far
  output logic [WIDTH-1:0] value_next // Value including this cycle's byte
);
  if (WIDTH < 16 || WIDTH % 8 != 0) begin : g_bad_width
    $error("lcsp_value_acc: WIDTH must be a byte multiple of 16 or more");
  end

  // Excess leading bytes fall off the top
  assign value_next = shift ? {value_q[WIDTH-9:0], data_byte} : value_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_q <= '0;
    end else if (clear) begin
      value_q <= '0;
    end else begin
      value_q <= value_next;
    end
  end
endmodule : lcsp_value_acc

// ===== tb/lcsp_host_model.sv
// Initiator model: offers command blocks and Data Out parameter lists
`timescale 1ns/1ps
module lcsp_host_model (
  input wire logic clk, // Clock
  output logic cmd_valid, // Command offered
  output logic [79:0] cmd_cdb, // Command block
  input wire logic cmd_busy, // Command in progress
  output logic dout_valid, // Byte offered
  output logic [7:0] dout_data, // Byte
  input wire logic dout_ready // Byte taken
);
  initial begin
    cmd_valid = 1'b0;
    cmd_cdb = 80'h0;
    dout_valid = 1'b0;
    dout_data = 8'h00;
  end
  // Call just after a rising edge; released lines show the inverse value
  task automatic send(input logic [79:0] cdb, input logic [7:0] lst[$]);
    cmd_valid <= 1'b1;
    cmd_cdb <= {cdb[79:65], 1'b0, cdb[63:0]};
    @(negedge clk);
    while (cmd_busy !== 1'b0) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_cdb <= ~cdb;
    foreach (lst[i]) begin
      dout_valid <= 1'b1;
      dout_data <= lst[i];
      @(negedge clk);
      while (dout_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    dout_valid <= 1'b0;
    dout_data <= ~dout_data;
  endtask : send
endmodule : lcsp_host_model

// ===== tb/tb.sv
// Self-checking bench for the log counter select parser
`timescale 1ns/1ps
module tb;
  logic clk, rst, cmd_valid, cmd_busy, dout_valid, dout_ready, cmd_done, cmd_check;
  logic [79:0] cmd_cdb;
  logic [7:0] dout_data, sense_asc, sense_ascq, sense_fsc;
  logic [3:0] sense_key;
  logic upd_valid, upd_page, thr_met, thr_met_page, rd_page, rd_etc, rd_du;
  logic [2:0] upd_idx, thr_met_idx, rd_idx;
  logic [39:0] upd_value, rd_cum, rd_thr;
  logic [1:0] rd_tmc;
  int err_total, compares;
  lcsp_parser u_dut (.clk, .rst, .cmd_valid, .cmd_cdb, .cmd_busy, .dout_valid, .dout_data,
    .dout_ready, .cmd_done, .cmd_check, .sense_key, .sense_asc, .sense_ascq, .sense_fsc,
    .upd_valid, .upd_page, .upd_idx, .upd_value, .thr_met, .thr_met_page, .thr_met_idx,
    .rd_page, .rd_idx, .rd_cum, .rd_thr, .rd_etc, .rd_du, .rd_tmc);
  lcsp_host_model u_host (.clk, .cmd_valid, .cmd_cdb, .cmd_busy, .dout_valid, .dout_data,
    .dout_ready);
  // ----------------------------------------------------------------
  // Checks and drivers
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [79:0] mk(input logic [7:0] b1, input logic [7:0] b2,
      input logic [15:0] len, input logic [7:0] b9);
    return {8'h4C, b1, b2, 32'hA5A5_A5A5, len, b9};
  endfunction : mk
  task automatic run(input logic [79:0] cdb, input logic [7:0] lst[$], input logic ill);
    int n;
    logic rdy;
    u_host.send(cdb, lst);
    n = 0;
    rdy = 1'b0;
    do begin
      @(negedge clk);
      rdy = rdy | dout_ready;
      n++;
    end while (cmd_done !== 1'b1 && n < 20);
    chk(cmd_done, 1'b1);
    chk(rdy, 1'b0);
    chk(cmd_check, ill);
    chk({sense_key, sense_asc, sense_ascq, sense_fsc}, ill ? 28'h524_00CE : 28'h0);
    @(posedge clk);
  endtask : run
  task automatic rd(input logic pg, input logic [2:0] ix, input logic [39:0] cum,
      input logic [39:0] thr, input logic threshold_compare_enable);
    rd_page <= pg;
    rd_idx <= ix;
    @(posedge clk);
    @(negedge clk);
    chk(rd_cum, cum);
    chk(rd_thr, thr);
    chk(rd_etc, threshold_compare_enable);
    @(posedge clk);
  endtask : rd
  task automatic upd(input logic pg, input logic [2:0] ix, input logic [39:0] v, input logic m);
    upd_valid <= 1'b1;
    upd_page <= pg;
    upd_idx <= ix;
    upd_value <= v;
    @(posedge clk);
    upd_valid <= 1'b0;
    @(negedge clk);
    chk(thr_met, m);
    if (m) chk({thr_met_page, thr_met_idx}, {pg, ix});
    @(posedge clk);
  endtask : upd
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_thresholds;
    run(mk(8'h00, 8'h3F, 16'd21, 8'h00), '{8'h02, 8'h00, 8'h00, 8'h07, 8'h00, 8'h02, 8'h14,
      8'h03, 8'h12, 8'h34, 8'h56, 8'hC3, 8'hFF, 8'h00, 8'h06, 8'h00, 8'h06, 8'h6E, 8'h02,
      8'hAB, 8'hCD}, 1'b0);
    rd(1'b0, 3'h0, 40'h0, 40'h123456, 1'b1);
    chk(rd_tmc, 2'h1);
    rd(1'b1, 3'h4, 40'h0, 40'hABCD, 1'b0);
    chk(rd_tmc, 2'h3);
  endtask : t_thresholds
  task automatic t_cumulative;
    run(mk(8'h00, 8'h40, 16'd18, 8'h00), '{8'h02, 8'h00, 8'h00, 8'h0E, 8'h00, 8'h05, 8'h00,
      8'h05, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h00, 8'h03, 8'h00, 8'h01, 8'h07}, 1'b0);
    rd(1'b0, 3'h3, 40'h01_0203_0405, 40'hFF_FFFF_FFFF, 1'b0);
    rd(1'b0, 3'h1, 40'h7, 40'hFF_FFFF, 1'b0);
  endtask : t_cumulative
  task automatic t_illegal;
    logic [79:0] c [5];
    c = '{mk(8'h02, 8'h00, 16'd1, 8'h00), mk(8'h00, 8'h80, 16'd1, 8'h00),
      mk(8'h00, 8'hC0, 16'd2, 8'h00), mk(8'h00, 8'h00, 16'd256, 8'h00),
      mk(8'h00, 8'h00, 16'd0, 8'h00)};
    foreach (c[i]) run(c[i], '{}, i < 4);
    rd(1'b0, 3'h0, 40'h0, 40'h123456, 1'b1);
  endtask : t_illegal
  task automatic t_criteria;
    logic [7:0] c;
    for (int t = 0; t < 5; t++) begin
      c = (t == 4) ? 8'h90 : 8'h10 | 8'(t << 2);
      run(mk(8'h00, 8'h00, 16'd10, 8'h00), '{8'h02, 8'h00, 8'h00, 8'h06, 8'h00, 8'h06, c,
        8'h02, 8'h00, 8'h10}, 1'b0);
      upd(1'b0, 3'h4, 40'h10, t < 2);
      upd(1'b0, 3'h4, 40'hFF0011, t != 1 && t != 4);
    end
    rd(1'b0, 3'h4, 40'h11, 40'h10, 1'b1);
    chk(rd_du, 1'b1);
  endtask : t_criteria
  task automatic t_bulk;
    run(mk(8'h00, 8'h80, 16'd0, 8'h00), '{}, 1'b0);
    rd(1'b0, 3'h3, 40'h01_0203_0405, 40'hFF_FFFF_FFFF, 1'b0);
    rd(1'b0, 3'h0, 40'h0, 40'hFF_FFFF, 1'b0);
    run(mk(8'h00, 8'hC0, 16'd0, 8'h00), '{}, 1'b0);
    rd(1'b0, 3'h3, 40'h0, 40'hFF_FFFF_FFFF, 1'b0);
  endtask : t_bulk
  task automatic t_reset_all;
    t_thresholds();
    upd(1'b0, 3'h1, 40'h5, 1'b0);
    run(mk(8'h02, 8'h40, 16'd0, 8'hC0), '{}, 1'b0);
    rd(1'b0, 3'h0, 40'h0, 40'hFF_FFFF, 1'b0);
    rd(1'b0, 3'h1, 40'h0, 40'hFF_FFFF, 1'b0);
    rd(1'b1, 3'h4, 40'h0, 40'hFFFF, 1'b0);
  endtask : t_reset_all
  task automatic report_and_stop;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    {upd_valid, upd_page, upd_idx, upd_value, rd_page, rd_idx} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_thresholds();
    t_cumulative();
    t_illegal();
    t_criteria();
    t_bulk();
    t_reset_all();
    report_and_stop();
  end
endmodule : tb
